// [hw/dcc_pkg.sv]
/*
 Shared constants of the checksum engine: register indices,
 field positions, source, polynomial and beat codes, reset values.
 Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
package dcc_pkg;
	// Address width of the register window
	localparam int AW = 8;
	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_ENA = 6'h00;
	localparam logic [5:0] IDX_CTRL = 6'h02;
	localparam logic [5:0] IDX_DIN = 6'h04;
	localparam logic [5:0] IDX_SUM = 6'h08;
	localparam logic [5:0] IDX_STAT = 6'h0c;
	localparam logic [5:0] IDX_IST = 6'h10;
	localparam logic [5:0] IDX_IMSK = 6'h11;
	// Control field positions
	localparam int SRC_LO = 8;
	localparam int POLY_LO = 2;
	localparam int BEAT_LO = 0;
	// Source codes
	localparam logic [5:0] SRC_NONE = 6'h00;
	localparam logic [5:0] SRC_IO = 6'h01;
	localparam logic [5:0] SRC_DMA = 6'h20;
	// Polynomial and beat codes
	localparam logic [1:0] POLY16 = 2'h0;
	localparam logic [1:0] POLY32 = 2'h1;
	localparam logic [1:0] BEAT8 = 2'h0;
	localparam logic [1:0] BEAT16 = 2'h1;
	localparam logic [1:0] BEAT32 = 2'h2;
	localparam logic [1:0] BEAT_RSV = 2'h3;
	// Generator polynomials, MSB-first form
	localparam logic [31:0] GEN32 = 32'h04c1_1db7;
	localparam logic [15:0] GEN16 = 16'h1021;
	// Reset values
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [31:0] WORD_RST = 32'h0000_0000;
	// Status and interrupt bit positions
	localparam int ST_BUSY = 0;
	localparam int ST_ZERO = 1;
	localparam int EV_DONE = 0;
	localparam int EV_ZERO = 1;
	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Byte-lane mask from write strobes
	function automatic logic [31:0] lane_mask(input logic [3:0] s);
		lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction
endpackage

// [hw/dcc_crc_engine.sv]
/*
 One checksum step over a 1, 2 or 4 byte beat, bytes taken lowest first.
 Assumes the caller starts it only when idle and with legal codes.
*/
`timescale 1ns/1ps
`default_nettype none
module dcc_crc_engine (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Sync reset, low
	input wire logic start, // Begin one beat
	input wire logic [31:0] data, // Beat data
	input wire logic [1:0] beat, // Beat size code
	input wire logic [1:0] poly, // Polynomial code
	input wire logic [31:0] crc_in, // Running checksum
	output logic busy, // Step in progress
	output logic done, // Result ready this cycle
	output logic [31:0] crc_out // Updated checksum
);
	import dcc_pkg::*;

	logic [1:0] cnt; // Cycles left
	logic [31:0] next_crc; // Whole-beat result

	// Fold the beat in bit by bit
	always_comb begin
		logic [31:0] c;
		logic fb;
		int nb;
		c = crc_in;
		fb = 1'b0;
		nb = (beat == BEAT32) ? 4 : int'(beat) + 1;
		for (int i = 0; i < 4; i++) begin
			for (int b = 0; b < 8; b++) begin
				if (i < nb) begin
					if (poly == POLY32) begin
						// Bytes go LSB first so the raw register is the mirrored residue
						fb = c[31] ^ data[8*i+b];
						c = {c[30:0], 1'b0} ^ (fb ? GEN32 : WORD_RST);
					end else begin
						fb = c[15] ^ data[8*i+7-b];
						c = {16'h0000, c[14:0], 1'b0} ^ (fb ? {16'h0000, GEN16} : WORD_RST);
					end
				end
			end
		end
		next_crc = c;
	end

	// Hold the result for beat code plus one cycles
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy <= 1'b0;
			cnt <= 2'h0;
			crc_out <= WORD_RST;
		end else if (start) begin
			busy <= 1'b1;
			cnt <= beat;
			crc_out <= next_crc;
		end else if (busy) begin
			if (cnt == 2'h0) begin
				busy <= 1'b0;
			end else begin
				cnt <= cnt - 2'h1;
			end
		end
	end

	assign done = busy && (cnt == 2'h0);
endmodule
`default_nettype wire

// [hw/dcc_axil_slave.sv]
/*
 AXI4-Lite slave front end: one write and one read at a time.
 Assumes register contents are decoded by the parent, same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module dcc_axil_slave #(
	parameter int AW = 8 // Address width
) (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Sync reset, low
	input wire logic [AW-1:0] awaddr, // Write address
	input wire logic awvalid, // Write address valid
	output logic awready, // Write address ready
	input wire logic [31:0] wdata, // Write data
	input wire logic [3:0] wstrb, // Write strobes
	input wire logic wvalid, // Write data valid
	output logic wready, // Write data ready
	output logic [1:0] bresp, // Write response
	output logic bvalid, // Write response valid
	input wire logic bready, // Write response ready
	input wire logic [AW-1:0] araddr, // Read address
	input wire logic arvalid, // Read address valid
	output logic arready, // Read address ready
	output logic [31:0] rdata, // Read data
	output logic [1:0] rresp, // Read response
	output logic rvalid, // Read valid
	input wire logic rready, // Read ready
	output logic wr_en, // Register write pulse
	output logic [AW-1:0] wr_addr, // Held write address
	output logic [31:0] wr_data, // Held write data
	output logic [3:0] wr_strb, // Held strobes
	input wire logic wr_err, // Write address unmapped
	input wire logic wr_stall, // Parent not ready
	input wire logic [31:0] rd_data, // Data at araddr
	input wire logic rd_err // Read address unmapped
);
	import dcc_pkg::*;

	logic aw_full; // Address held
	logic w_full; // Data held

	assign awready = !aw_full;
	assign wready = !w_full;
	assign arready = !rvalid;
	// Stall holds the write unanswered until the parent can take it
	assign wr_en = aw_full && w_full && !bvalid && !wr_stall;

	// Capture address and data in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			wr_addr <= '0;
			wr_data <= WORD_RST;
			wr_strb <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_full <= 1'b1;
				wr_addr <= awaddr;
			end else if (wr_en) begin
				aw_full <= 1'b0;
			end
			if (wvalid && wready) begin
				w_full <= 1'b1;
				wr_data <= wdata;
				wr_strb <= wstrb;
			end else if (wr_en) begin
				w_full <= 1'b0;
			end
		end
	end

	// Write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (wr_en) begin
			bvalid <= 1'b1;
			bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// Read answer registered one cycle after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= WORD_RST;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata <= rd_err ? WORD_RST : rd_data;
			rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [hw/dcc_checksum_engine.sv]
/*
 Checksum engine of a DMA controller: CRC-16/CRC-32 over data written by
 software or fed by one selected DMA channel, behind AXI4-Lite.
 Assumes the channel enables and beat stream come from logic on aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module dcc_checksum_engine #(
	parameter int NCH = 32 // Number of DMA channels
) (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Sync reset, low
	input wire logic [dcc_pkg::AW-1:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [dcc_pkg::AW-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read valid
	input wire logic s_axi_rready, // Read ready
	input wire logic [NCH-1:0] dma_chan_enable, // Channel enables
	input wire logic dma_beat_valid, // Channel beat offered
	output logic dma_beat_ready, // Beat taken
	input wire logic [4:0] dma_beat_chan, // Offering channel
	input wire logic [31:0] dma_beat_data, // Beat data
	input wire logic [1:0] dma_beat_size, // Beat size code
	output logic irq // Level interrupt
);
	import dcc_pkg::*;

	////////////////////////////////////////////////////////////////
	// Declarations

	logic wr_en; // Register write pulse
	logic [AW-1:0] wr_addr; // Write address
	logic [31:0] wr_data; // Write data
	logic [3:0] wr_strb; // Write strobes
	logic [31:0] wmask; // Strobe mask
	logic wr_err; // Write unmapped
	logic [31:0] rd_data; // Read mux
	logic rd_err; // Read unmapped
	logic checksum_enable; // Engine enabled
	logic [5:0] input_source_select; // Source code
	logic [1:0] polynomial_select; // Polynomial code
	logic [1:0] input_beat_width; // Beat size code
	logic [31:0] checksum_input_word; // Data input register
	logic [31:0] checksum_value; // Raw checksum
	logic engine_busy_flag; // Source lock
	logic busy_q; // Busy one cycle ago
	logic zero_result_flag; // Zero at completion
	logic [1:0] ev_status; // Sticky events
	logic [1:0] ev_mask; // Event mask
	logic wr_ena, wr_ctrl, wr_din, wr_sum, wr_stat, wr_ist, wr_imsk; // Write hits
	logic src_io; // Register-fed source
	logic src_dma; // Channel source
	logic [4:0] sel_chan; // Selected channel
	logic sel_chan_en; // Selected channel enabled
	logic cfg_ok; // Legal polynomial and beat
	logic [31:0] next_din; // Data input after write
	logic io_start; // Register beat starts
	logic dma_take; // Channel beat taken
	logic eng_start; // Engine start
	logic [31:0] eng_data; // Engine data
	logic [1:0] eng_beat; // Engine beat code
	logic eng_busy; // Engine running
	logic eng_done; // Engine result ready
	logic [31:0] eng_out; // Engine result
	logic done_ev; // Run completed
	logic sum_zero; // Checksum is zero
	logic [31:0] sum_rev; // Mirrored checksum
	logic [31:0] sum_read; // Checksum as read

	////////////////////////////////////////////////////////////////
	// Bus slave and address decode

	dcc_axil_slave #(.AW(AW)) u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(s_axi_awaddr),
		.awvalid(s_axi_awvalid),
		.awready(s_axi_awready),
		.wdata(s_axi_wdata),
		.wstrb(s_axi_wstrb),
		.wvalid(s_axi_wvalid),
		.wready(s_axi_wready),
		.bresp(s_axi_bresp),
		.bvalid(s_axi_bvalid),
		.bready(s_axi_bready),
		.araddr(s_axi_araddr),
		.arvalid(s_axi_arvalid),
		.arready(s_axi_arready),
		.rdata(s_axi_rdata),
		.rresp(s_axi_rresp),
		.rvalid(s_axi_rvalid),
		.rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_err(wr_err),
		.wr_stall(eng_busy),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	assign wmask = lane_mask(wr_strb);
	// Write hits; low address bits are ignored, words only
	assign wr_ena = wr_en && (wr_addr[AW-1:2] == IDX_ENA);
	assign wr_ctrl = wr_en && (wr_addr[AW-1:2] == IDX_CTRL);
	assign wr_din = wr_en && (wr_addr[AW-1:2] == IDX_DIN);
	assign wr_sum = wr_en && (wr_addr[AW-1:2] == IDX_SUM);
	assign wr_stat = wr_en && (wr_addr[AW-1:2] == IDX_STAT);
	assign wr_ist = wr_en && (wr_addr[AW-1:2] == IDX_IST);
	assign wr_imsk = wr_en && (wr_addr[AW-1:2] == IDX_IMSK);
	assign wr_err = !(wr_ena || wr_ctrl || wr_din || wr_sum || wr_stat || wr_ist || wr_imsk) && wr_en;

	////////////////////////////////////////////////////////////////
	// Source decode

	// Codes 0x02..0x1f and 0x00 fall through as no source
	assign src_io = (input_source_select == SRC_IO);
	assign src_dma = input_source_select[5];
	assign sel_chan = input_source_select[4:0];
	assign sel_chan_en = (int'(sel_chan) < NCH) && dma_chan_enable[sel_chan];
	// Reserved polynomial or beat codes never start a step
	assign cfg_ok = (polynomial_select == POLY16 || polynomial_select == POLY32)
		&& (input_beat_width != BEAT_RSV);

	////////////////////////////////////////////////////////////////
	// Enable bit

	// Disable only takes once the source has let go
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			checksum_enable <= 1'b0;
		end else if (wr_ena && wr_strb[0]) begin
			if (wr_data[0]) begin
				checksum_enable <= 1'b1;
			end else if (!engine_busy_flag) begin
				checksum_enable <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Control register

	// Locked while enabled or busy so the source cannot change mid-run
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			input_source_select <= CTRL_RST[SRC_LO +: 6];
			polynomial_select <= CTRL_RST[POLY_LO +: 2];
			input_beat_width <= CTRL_RST[BEAT_LO +: 2];
		end else if (wr_ctrl && !checksum_enable && !engine_busy_flag) begin
			if (wr_strb[1]) begin
				input_source_select <= wr_data[SRC_LO +: 6];
			end
			if (wr_strb[0]) begin
				polynomial_select <= wr_data[POLY_LO +: 2];
				input_beat_width <= wr_data[BEAT_LO +: 2];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Busy flag

	// Register source: set by enabling, cleared by software write of one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			engine_busy_flag <= 1'b0;
		end else if (src_dma) begin
			engine_busy_flag <= checksum_enable && sel_chan_en;
		end else if (src_io && wr_ena && wr_strb[0] && wr_data[0] && !checksum_enable) begin
			engine_busy_flag <= 1'b1;
		end else if (src_io && wr_stat && wr_strb[0] && wr_data[ST_BUSY]) begin
			engine_busy_flag <= 1'b0;
		end
	end

	// Completion is the falling edge of busy
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= engine_busy_flag;
		end
	end

	assign done_ev = busy_q && !engine_busy_flag;

	////////////////////////////////////////////////////////////////
	// Data input and engine feed

	assign next_din = (checksum_input_word & ~wmask) | (wr_data & wmask);
	assign io_start = wr_din && checksum_enable && src_io && engine_busy_flag && cfg_ok;
	// A channel beat waits while the engine is still folding the last one
	assign dma_beat_ready = checksum_enable && src_dma && engine_busy_flag && cfg_ok
		&& !eng_busy && (dma_beat_chan == sel_chan) && (dma_beat_size != BEAT_RSV);
	assign dma_take = dma_beat_valid && dma_beat_ready;
	assign eng_start = io_start || dma_take;
	assign eng_data = dma_take ? dma_beat_data : next_din;
	assign eng_beat = dma_take ? dma_beat_size : input_beat_width;

	// Data input register keeps the last written word
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			checksum_input_word <= WORD_RST;
		end else if (wr_din) begin
			checksum_input_word <= next_din;
		end
	end

	dcc_crc_engine u_eng (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(eng_start),
		.data(eng_data),
		.beat(eng_beat),
		.poly(polynomial_select),
		.crc_in(checksum_value),
		.busy(eng_busy),
		.done(eng_done),
		.crc_out(eng_out)
	);

	////////////////////////////////////////////////////////////////
	// Checksum register

	// Software preset only while disabled
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			checksum_value <= WORD_RST;
		end else if (eng_done) begin
			checksum_value <= eng_out;
		end else if (wr_sum && !checksum_enable) begin
			checksum_value <= (checksum_value & ~wmask) | (wr_data & wmask);
		end
	end

	// Mirror for CRC-32 readout
	generate
		for (genvar g = 0; g < 32; g++) begin : g_rev
			assign sum_rev[g] = checksum_value[31-g];
		end
	endgenerate

	always_comb begin
		if (polynomial_select == POLY32 && !engine_busy_flag) begin
			sum_read = ~sum_rev;
		end else if (polynomial_select == POLY16) begin
			sum_read = {16'h0000, checksum_value[15:0]};
		end else begin
			sum_read = checksum_value;
		end
	end

	assign sum_zero = (polynomial_select == POLY16) ? (checksum_value[15:0] == 16'h0000)
		: (checksum_value == WORD_RST);

	////////////////////////////////////////////////////////////////
	// Zero flag

	// Completion wins over a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			zero_result_flag <= 1'b0;
		end else if (done_ev && sum_zero) begin
			zero_result_flag <= 1'b1;
		end else if (wr_ctrl && wr_strb[1] && !checksum_enable && !engine_busy_flag) begin
			zero_result_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Interrupt status and mask

	// Write one to clear; a new event in the same cycle stays set
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ev_status <= 2'h0;
		end else begin
			ev_status[EV_DONE] <= done_ev
				|| (ev_status[EV_DONE] && !(wr_ist && wr_strb[0] && wr_data[EV_DONE]));
			ev_status[EV_ZERO] <= (done_ev && sum_zero)
				|| (ev_status[EV_ZERO] && !(wr_ist && wr_strb[0] && wr_data[EV_ZERO]));
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ev_mask <= 2'h0;
		end else if (wr_imsk && wr_strb[0]) begin
			ev_mask <= wr_data[1:0];
		end
	end

	assign irq = |(ev_status & ev_mask);

	////////////////////////////////////////////////////////////////
	// Read mux

	always_comb begin
		rd_data = WORD_RST;
		rd_err = 1'b0;
		unique case (s_axi_araddr[AW-1:2])
			IDX_ENA: rd_data[0] = checksum_enable;
			IDX_CTRL: begin
				rd_data[SRC_LO +: 6] = input_source_select;
				rd_data[POLY_LO +: 2] = polynomial_select;
				rd_data[BEAT_LO +: 2] = input_beat_width;
			end
			IDX_DIN: rd_data = checksum_input_word;
			IDX_SUM: rd_data = sum_read;
			IDX_STAT: begin
				rd_data[ST_BUSY] = engine_busy_flag;
				rd_data[ST_ZERO] = zero_result_flag;
			end
			IDX_IST: rd_data[1:0] = ev_status;
			IDX_IMSK: rd_data[1:0] = ev_mask;
			default: rd_err = 1'b1;
		endcase
	end
endmodule
`default_nettype wire

// [tb/dcc_checksum_engine_sva.sv]
/*
 Port-level checker for the checksum engine.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module dcc_checksum_engine_sva
	import dcc_pkg::*;
#(
	parameter int NCH = 32 // Channel count
) (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset, low
	input wire logic [dcc_pkg::AW-1:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Address valid
	input wire logic s_axi_awready, // Address ready
	input wire logic s_axi_wvalid, // Data valid
	input wire logic s_axi_wready, // Data ready
	input wire logic [1:0] s_axi_bresp, // Write answer
	input wire logic s_axi_bvalid, // Answer valid
	input wire logic [dcc_pkg::AW-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read valid
	input wire logic s_axi_arready, // Read ready
	input wire logic [31:0] s_axi_rdata, // Read data
	input wire logic [1:0] s_axi_rresp, // Read answer
	input wire logic s_axi_rvalid, // Data valid
	input wire logic dma_beat_valid, // Beat offered
	input wire logic dma_beat_ready, // Beat taken
	input wire logic [1:0] dma_beat_size // Beat size
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////
	// Read channel: one answer, exactly one cycle after the address
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
	ar_free_a: assert property (s_axi_arready == !s_axi_rvalid) else $error("read ready wrong");
	rd_spont_a: assert property (!s_axi_rvalid && !(s_axi_arvalid && s_axi_arready) |=> !s_axi_rvalid)
		else $error("read answer unasked");
	// Write answer is bounded: stall of three folding cycles at most
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:5] s_axi_bvalid) else $error("write answer late");
	// Hole at 0x04 answers with an error and no data
	unmap_rd_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h04
		|=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000) else $error("hole read ok");
	unmap_wr_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'h04 && s_axi_wvalid
		|-> ##[1:5] s_axi_bvalid && s_axi_bresp == RESP_SLVERR) else $error("hole write ok");
	// Engine folds a taken beat before it takes another
	beat_gap_a: assert property (dma_beat_valid && dma_beat_ready |=> !dma_beat_ready) else $error("beat overrun");
	beat_wide_a: assert property (dma_beat_valid && dma_beat_ready && dma_beat_size == BEAT32
		|=> !dma_beat_ready [*2]) else $error("word beat too fast");
endmodule
bind dcc_checksum_engine dcc_checksum_engine_sva #(.NCH(NCH)) u_sva (.*);
`default_nettype wire

// [tb/dcc_dma_model.sv]
/*
 Behavioural DMA channel side: channel enables and a beat stream.
 Assumes the bench calls its tasks; same clock as the engine.
*/
`timescale 1ns/1ps
`default_nettype none
module dcc_dma_model (
	input wire logic aclk, // Clock
	input wire logic dma_beat_ready, // Beat taken
	output logic [31:0] dma_chan_enable, // Channel enables
	output logic dma_beat_valid, // Beat offered
	output logic [4:0] dma_beat_chan, // Offering channel
	output logic [31:0] dma_beat_data, // Beat data
	output logic [1:0] dma_beat_size // Beat size
);
	int cur = 0; // Last channel touched
	initial begin
		dma_chan_enable = 32'h0000_0000;
		dma_beat_valid = 1'b0;
		dma_beat_chan = 5'h00;
		dma_beat_data = 32'h5555_aaaa;
		dma_beat_size = 2'h3;
	end
	////////////////////////////////////////////////////////////////
	// Channel on or off; switching off is what ends a channel run
	task automatic chan(input int n, input logic en);
		@(posedge aclk);
		dma_chan_enable[n] <= en;
		cur = n;
	endtask
	// One beat, offered after gap idle cycles, held until taken
	task automatic send(input logic [31:0] d, input logic [1:0] sz, input int gap);
		logic t;
		repeat (gap) @(posedge aclk);
		dma_beat_valid <= 1'b1;
		dma_beat_chan <= 5'(cur);
		dma_beat_data <= d;
		dma_beat_size <= sz;
		do begin
			@(negedge aclk);
			t = dma_beat_ready;
			@(posedge aclk);
		end while (!t);
		dma_beat_valid <= 1'b0;
		// Released lines show junk so stale data is never reused
		dma_beat_data <= ~d;
		dma_beat_size <= ~sz;
	endtask
endmodule
`default_nettype wire

// [tb/dcc_checksum_engine_tb.sv]
/*
 Self-checking bench for the checksum engine and its register bus.
 Assumes the DMA side model and the bound checker are compiled.
*/
`timescale 1ns/1ps
`default_nettype none
module dcc_checksum_engine_tb;
	import dcc_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0; // Clock and reset
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00; // Addresses
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0; // Write side
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0; // Read side
	logic [31:0] s_axi_wdata = 32'h0000_0000; // Write data
	logic [3:0] s_axi_wstrb = 4'hf; // All lanes
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, dma_beat_ready, dma_beat_valid;
	logic [1:0] s_axi_bresp, s_axi_rresp, dma_beat_size, rs;
	logic [31:0] s_axi_rdata, dma_beat_data, dma_chan_enable, rv, c32;
	logic [4:0] dma_beat_chan;
	logic [31:0] msg = 32'h3433_3231; // Sample payload
	int error_cnt = 0, n_checks = 0;
	dcc_checksum_engine #(.NCH(32)) u_dcc_checksum_engine (.*);
	dcc_dma_model u_dcc_dma_model (.*);
	initial forever #5 aclk = ~aclk;
	////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// Reference checksum, bit by bit; bytes lowest first
	function automatic logic [31:0] fold(input logic [31:0] c, input logic [31:0] d, input int nb, input logic p32);
		logic fb;
		for (int k = 0; k < nb * 8; k++) begin
			fb = p32 ? c[31] ^ d[k] : c[15] ^ d[(k / 8) * 8 + 7 - k % 8];
			c = p32 ? {c[30:0], 1'b0} : {16'h0000, c[14:0], 1'b0};
			if (fb) c = c ^ (p32 ? GEN32 : {16'h0000, GEN16});
		end
		return c;
	endfunction
	function automatic logic [31:0] brev(input logic [31:0] x);
		for (int k = 0; k < 32; k++) brev[k] = x[31 - k];
	endfunction
	function automatic logic [31:0] ctl(input logic [5:0] s, input logic [1:0] p, input logic [1:0] b);
		return {18'h0_0000, s, 4'h0, p, b};
	endfunction
	////////////////////////////////////////////////////////////////
	// Bus write: both channels offered, each dropped once taken
	task automatic wr(input logic [5:0] i, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge aclk);
		s_axi_awaddr <= {i, 2'b00};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tb = s_axi_bvalid;
			rs = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end while (!tb);
		s_axi_bready <= 1'b0;
	endtask
	// Bus read and compare; the lead-in covers a beat still folding
	task automatic rdc(input logic [5:0] i, input logic [31:0] exp);
		logic ta, tr;
		repeat (3) @(posedge aclk);
		s_axi_araddr <= {i, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = s_axi_arvalid & s_axi_arready;
			tr = s_axi_rvalid;
			rv = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
		end while (!tr);
		s_axi_rready <= 1'b0;
		check(rv, exp);
	endtask
	task automatic irqc(input logic exp);
		@(negedge aclk);
		check(32'(irq), 32'(exp));
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rdc(IDX_CTRL, 32'h0000_0000);
		rdc(IDX_SUM, 32'h0000_0000);
		rdc(IDX_STAT, 32'h0000_0000);
		rdc(6'h01, 32'h0000_0000);
		check({30'h0, rs}, {30'h0, RESP_SLVERR});
		wr(6'h01, 32'h0000_0001);
		check({30'h0, rs}, {30'h0, RESP_SLVERR});
	endtask
	// Uncomplemented checksum appended: raw ends at zero; event interrupt
	task automatic t_zero;
		c32 = ~brev(fold(32'hffff_ffff, msg, 4, 1'b1));
		wr(IDX_CTRL, ctl(SRC_IO, POLY32, BEAT32));
		wr(IDX_SUM, 32'hffff_ffff);
		wr(IDX_ENA, 32'h0000_0001);
		rdc(IDX_STAT, 32'h0000_0001);
		wr(IDX_DIN, msg);
		wr(IDX_DIN, ~c32);
		wr(IDX_STAT, 32'h0000_0001);
		rdc(IDX_STAT, 32'h0000_0002);
		rdc(IDX_SUM, 32'hffff_ffff);
		rdc(IDX_IST, 32'h0000_0003);
		irqc(1'b0);
		wr(IDX_IMSK, 32'h0000_0002);
		irqc(1'b1);
		wr(IDX_IST, 32'h0000_0002);
		irqc(1'b0);
		rdc(IDX_IST, 32'h0000_0001);
		wr(IDX_ENA, 32'h0000_0000);
		rdc(IDX_ENA, 32'h0000_0000);
	endtask
	// Plain checksum appended: residue, locks while running
	task automatic t_run32;
		wr(IDX_CTRL, ctl(SRC_IO, POLY32, BEAT32));
		rdc(IDX_STAT, 32'h0000_0000);
		wr(IDX_SUM, 32'hffff_ffff);
		wr(IDX_ENA, 32'h0000_0001);
		wr(IDX_DIN, msg);
		rdc(IDX_SUM, fold(32'hffff_ffff, msg, 4, 1'b1));
		wr(IDX_CTRL, 32'h0000_0000);
		rdc(IDX_CTRL, ctl(SRC_IO, POLY32, BEAT32));
		wr(IDX_SUM, 32'h0000_0000);
		wr(IDX_ENA, 32'h0000_0000);
		rdc(IDX_ENA, 32'h0000_0001);
		wr(IDX_DIN, c32);
		wr(IDX_STAT, 32'h0000_0001);
		rdc(IDX_STAT, 32'h0000_0000);
		rdc(IDX_SUM, 32'h2144_df1c);
		wr(IDX_ENA, 32'h0000_0000);
	endtask
	// Every beat code under CRC-16, reserved one included, then a reserved polynomial
	task automatic t_crc16;
		for (int b = 0; b < 5; b++) begin
			wr(IDX_CTRL, ctl(SRC_IO, b == 4 ? 2'h2 : POLY16, 2'(b)));
			wr(IDX_SUM, 32'hffff_ffff);
			wr(IDX_ENA, 32'h0000_0001);
			wr(IDX_DIN, msg);
			rdc(IDX_SUM, b > 2 ? 32'hffff_ffff >> (16 * (4 - b))
				: fold(32'h0000_ffff, msg, 1 << b, 1'b0));
			wr(IDX_STAT, 32'h0000_0001);
			wr(IDX_ENA, 32'h0000_0000);
		end
	endtask
	// Channel source: only channel 5 counts, it alone ends the run
	task automatic t_chan;
		wr(IDX_CTRL, ctl(SRC_DMA + 6'h05, POLY32, BEAT8));
		wr(IDX_SUM, 32'hffff_ffff);
		wr(IDX_ENA, 32'h0000_0001);
		u_dcc_dma_model.chan(6, 1'b1);
		rdc(IDX_STAT, 32'h0000_0000);
		u_dcc_dma_model.chan(5, 1'b1);
		rdc(IDX_STAT, 32'h0000_0001);
		u_dcc_dma_model.send(msg, BEAT32, 0);
		u_dcc_dma_model.send(32'h0000_0035, BEAT8, 4);
		wr(IDX_STAT, 32'h0000_0001);
		rdc(IDX_STAT, 32'h0000_0001);
		u_dcc_dma_model.chan(5, 1'b0);
		rdc(IDX_STAT, 32'h0000_0000);
		rdc(IDX_SUM, ~brev(fold(fold(32'hffff_ffff, msg, 4, 1'b1), 32'h35, 1, 1'b1)));
		wr(IDX_ENA, 32'h0000_0000);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_zero;
		t_run32;
		t_crc16;
		t_chan;
		wrap_up;
	end
	// Whole run is well under a thousand cycles
	initial begin
		#50000;
		error_cnt++;
		wrap_up;
	end
endmodule
`default_nettype wire
